// ===== oag_addr_gen.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.svh"
module oag_addr_gen (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoder request
	input wire logic op_valid,
	output logic op_ready,
	input wire oag_pkg::oag_mode_t op_mode,
	input wire oag_pkg::oag_tbl_t op_table,
	input wire oag_pkg::oag_dest_t op_dest,
	input wire logic op_byte,
	input wire logic op_dec,
	input wire logic [3:0] op_wn,
	input wire logic [3:0] op_wb,
	input wire logic [3:0] op_wd,
	input wire logic [15:0] op_addr,
	input wire logic [9:0] op_lit,
	// Result to memories
	output logic res_valid,
	output logic [15:0] res_ea,
	output logic res_ea_mem,
	output logic [15:0] res_operand,
	output logic [3:0] res_dest_reg,
	output logic res_dest_pair,
	output logic res_dest_mem,
	output logic [23:0] prog_addr,
	output oag_pkg::oag_tbl_t prog_op,
	output logic prog_byte,
	output logic prog_byte_hi
);
	import oag_pkg::*;

	// Map a register index onto a working register number
	function automatic logic [4:0] default_work_register_hit(input logic [15:0] idx);
		case (idx)
			`OAG_IDX_W0: default_work_register_hit = 5'h10;
			`OAG_IDX_W1: default_work_register_hit = 5'h11;
			`OAG_IDX_W2: default_work_register_hit = 5'h12;
			`OAG_IDX_W3: default_work_register_hit = 5'h13;
			`OAG_IDX_W4: default_work_register_hit = 5'h14;
			`OAG_IDX_W5: default_work_register_hit = 5'h15;
			`OAG_IDX_W6: default_work_register_hit = 5'h16;
			`OAG_IDX_W7: default_work_register_hit = 5'h17;
			`OAG_IDX_W8: default_work_register_hit = 5'h18;
			`OAG_IDX_W9: default_work_register_hit = 5'h19;
			`OAG_IDX_W10: default_work_register_hit = 5'h1a;
			`OAG_IDX_W11: default_work_register_hit = 5'h1b;
			`OAG_IDX_W12: default_work_register_hit = 5'h1c;
			`OAG_IDX_W13: default_work_register_hit = 5'h1d;
			`OAG_IDX_W14: default_work_register_hit = 5'h1e;
			`OAG_IDX_W15: default_work_register_hit = 5'h1f;
			default: default_work_register_hit = 5'h00;
		endcase
	endfunction

	// Step a pointer by one byte or one word
	function automatic logic [15:0] step_ptr(input logic [15:0] v,
		input logic dec, input logic byte_mode);
		logic [15:0] s;
		s = byte_mode ? `OAG_STEP_BYTE : `OAG_STEP_WORD;
		step_ptr = dec ? v - s : v + s;
	endfunction

	oag_state_t state_q, state_d;
	logic op_ready_q, pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic take_op, apb_acc;
	logic [15:0] apb_idx;
	logic [4:0] apb_w;
	logic apb_ok;
	// Captured request
	oag_mode_t mode_q;
	oag_tbl_t tbl_q;
	oag_dest_t dest_q;
	logic byte_q, dec_q;
	logic [3:0] wn_q, wd_q;
	logic [15:0] addr_q;
	logic [9:0] lit_q;
	// Software registers
	logic [15:0] stack_limit_q, last_ea_q;
	logic [9:0] rdpage_q;
	logic [8:0] wrpage_q;
	logic [7:0] pps_q;
	// Register file ports
	logic [3:0] ra_addr, wr_addr;
	logic [15:0] rd_a, rd_b, wr_data;
	logic wr_en;
	// Execute results
	logic [15:0] ea_d, opnd_d, mod_d;
	logic mem_d, mod_en;
	logic [23:0] prog_d;
	// Outputs
	logic res_valid_q, res_ea_mem_q, dest_pair_q, dest_mem_q;
	logic prog_byte_q, prog_byte_hi_q;
	logic [15:0] res_ea_q, res_operand_q;
	logic [3:0] dest_reg_q;
	logic [23:0] prog_addr_q;
	oag_tbl_t prog_op_q;

	// Handshakes and APB decode; paddr[1:0] must be zero
	assign take_op = (state_q == S_IDLE) && op_valid && op_ready_q;
	assign apb_acc = psel && penable && !pready_q;
	assign apb_idx = paddr[17:2];
	assign apb_w = default_work_register_hit(apb_idx);
	assign apb_ok = (paddr[1:0] == 2'b00) && (apb_w[4]
		|| apb_idx == `OAG_IDX_STACK_LIMIT || apb_idx == `OAG_IDX_RDPAGE
		|| apb_idx == `OAG_IDX_WRPAGE || apb_idx == `OAG_IDX_PPS
		|| apb_idx == `OAG_IDX_LAST_EA);

	// Sequencer: a decoder request wins over a waiting APB access
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (take_op) begin
					state_d = S_EXEC;
				end else if (apb_acc) begin
					state_d = S_APB;
				end
			end
			S_EXEC: state_d = S_IDLE;
			S_APB: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Not ready while APB is selected, so software is never starved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_ready_q <= 1'b0;
		end else begin
			op_ready_q <= (state_d == S_IDLE) && !psel && !take_op;
		end
	end

	// Capture the request when it is taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= M_FILE;
			tbl_q <= T_NONE;
			dest_q <= D_MEM;
			byte_q <= 1'b0;
			dec_q <= 1'b0;
			wn_q <= 4'h0;
			wd_q <= 4'h0;
			addr_q <= 16'h0000;
			lit_q <= 10'h000;
		end else if (take_op) begin
			mode_q <= op_mode;
			tbl_q <= op_table;
			dest_q <= op_dest;
			byte_q <= op_byte;
			dec_q <= op_dec;
			wn_q <= op_wn;
			wd_q <= op_wd;
			addr_q <= op_addr;
			lit_q <= op_lit;
		end
	end

	// Port a serves the base register or an APB read
	assign ra_addr = take_op ? op_wn : apb_w[3:0];

	// Writeback has the port in execute; APB writes in its own state
	always_comb begin
		wr_en = 1'b0;
		wr_addr = wn_q;
		wr_data = mod_d;
		if (state_q == S_EXEC) begin
			wr_en = mod_en;
		end else if (state_q == S_APB && pwrite && apb_ok && apb_w[4]) begin
			wr_en = 1'b1;
			wr_addr = apb_w[3:0];
			wr_data = pwdata[15:0];
		end
	end

	oag_default_work_register_mem u_wregs (
		.clk(pclk),
		.ra_addr(ra_addr),
		.ra_data(rd_a),
		.rb_addr(op_wb),
		.rb_data(rd_b),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	// Effective address and operand for each mode
	always_comb begin
		ea_d = 16'h0000;
		opnd_d = 16'h0000;
		mem_d = 1'b1;
		mod_d = step_ptr(rd_a, dec_q, byte_q);
		mod_en = 1'b0;
		case (mode_q)
			M_FILE: ea_d = {3'b000, addr_q[`OAG_FILE_BITS-1:0]};
			M_FAR: ea_d = addr_q;
			M_DIRECT: begin
				opnd_d = rd_a;
				mem_d = 1'b0;
			end
			M_IND: ea_d = rd_a;
			M_POST: begin
				ea_d = rd_a;
				mod_en = 1'b1;
			end
			M_PRE: begin
				ea_d = mod_d;
				mod_en = 1'b1;
			end
			M_INDEXED: ea_d = rd_a + rd_b;
			M_LITOFS: ea_d = rd_a + {{6{lit_q[9]}}, lit_q};
			M_LIT5: begin
				opnd_d = {11'h000, lit_q[4:0]};
				mem_d = 1'b0;
			end
			M_LIT10: begin
				opnd_d = {6'h00, lit_q};
				mem_d = 1'b0;
			end
			default: ea_d = rd_a;
		endcase
		// page select over the operand address
		prog_d = {pps_q, ea_d};
		if (tbl_q == T_ERASE) begin
			// erase aligns to a whole page
			prog_d = prog_d & `OAG_PAGE_MASK;
		end
	end

	// Result registers, valid for one cycle after execute
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid_q <= 1'b0;
			res_ea_q <= 16'h0000;
			res_ea_mem_q <= 1'b0;
			res_operand_q <= 16'h0000;
			last_ea_q <= 16'h0000;
		end else begin
			res_valid_q <= (state_q == S_EXEC);
			if (state_q == S_EXEC) begin
				res_ea_q <= ea_d;
				res_ea_mem_q <= mem_d;
				res_operand_q <= opnd_d;
				last_ea_q <= ea_d;
			end
		end
	end

	// Destination selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dest_reg_q <= 4'h0;
			dest_pair_q <= 1'b0;
			dest_mem_q <= 1'b0;
		end else if (state_q == S_EXEC) begin
			case (dest_q)
				// default working register is register 0
				D_DEFAULT_WORK_REGISTER: begin
					dest_reg_q <= 4'h0;
					dest_pair_q <= 1'b0;
					dest_mem_q <= 1'b0;
				end
				D_WN: begin
					dest_reg_q <= wd_q;
					dest_pair_q <= 1'b0;
					dest_mem_q <= 1'b0;
				end
				// product result to a register pair
				D_PAIR: begin
					dest_reg_q <= wd_q;
					dest_pair_q <= 1'b1;
					dest_mem_q <= 1'b0;
				end
				default: begin
					dest_reg_q <= 4'h0;
					dest_pair_q <= 1'b0;
					dest_mem_q <= 1'b1;
				end
			endcase
		end
	end

	// Program memory request; one word or one byte per write, no burst support
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_addr_q <= 24'h000000;
			prog_op_q <= T_NONE;
			prog_byte_q <= 1'b0;
			prog_byte_hi_q <= 1'b0;
		end else if (state_q == S_EXEC) begin
			prog_addr_q <= prog_d;
			prog_op_q <= tbl_q;
			prog_byte_q <= byte_q;
			prog_byte_hi_q <= byte_q && ea_d[0];
		end else begin
			prog_op_q <= T_NONE;
		end
	end

	// Software registers; the write page is left to software discipline
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_limit_q <= `OAG_RST_STACK_LIMIT;
			rdpage_q <= `OAG_RST_RDPAGE;
			wrpage_q <= `OAG_RST_WRPAGE;
			pps_q <= `OAG_RST_PPS;
		end else if (state_q == S_APB && pwrite && apb_ok) begin
			case (apb_idx)
				`OAG_IDX_STACK_LIMIT: stack_limit_q <= pwdata[15:0];
				`OAG_IDX_RDPAGE: rdpage_q <= pwdata[9:0];
				`OAG_IDX_WRPAGE: wrpage_q <= pwdata[8:0];
				`OAG_IDX_PPS: pps_q <= pwdata[7:0];
				default: pps_q <= pps_q;
			endcase
		end
	end

	// APB answer one cycle after the access state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= (state_q == S_APB);
			pslverr_q <= (state_q == S_APB) && !apb_ok;
			if (state_q == S_APB && !pwrite) begin
				// Refused accesses read zero, even at a mapped index
				if (!apb_ok) begin
					prdata_q <= 32'h00000000;
				end else if (apb_w[4]) begin
					prdata_q <= {16'h0000, rd_a};
				end else begin
					case (apb_idx)
						`OAG_IDX_STACK_LIMIT: prdata_q <= {16'h0000, stack_limit_q};
						`OAG_IDX_RDPAGE: prdata_q <= {22'h000000, rdpage_q};
						`OAG_IDX_WRPAGE: prdata_q <= {23'h000000, wrpage_q};
						`OAG_IDX_PPS: prdata_q <= {24'h000000, pps_q};
						`OAG_IDX_LAST_EA: prdata_q <= {16'h0000, last_ea_q};
						default: prdata_q <= 32'h00000000;
					endcase
				end
			end
		end
	end

	assign op_ready = op_ready_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;
	assign res_valid = res_valid_q;
	assign res_ea = res_ea_q;
	assign res_ea_mem = res_ea_mem_q;
	assign res_operand = res_operand_q;
	assign res_dest_reg = dest_reg_q;
	assign res_dest_pair = dest_pair_q;
	assign res_dest_mem = dest_mem_q;
	assign prog_addr = prog_addr_q;
	assign prog_op = prog_op_q;
	assign prog_byte = prog_byte_q;
	assign prog_byte_hi = prog_byte_hi_q;

	// Checks on the address paths, the pair destination and the APB answer timing
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_file_near_addr: assert property (
		state_q == S_EXEC && mode_q == M_FILE |=> res_valid
		&& res_ea_mem && res_ea == {3'b000, $past(addr_q[12:0])})
		else $error("file address wrong");
	a_far_transfer: assert property (
		state_q == S_EXEC && mode_q == M_FAR |=> res_ea == $past(addr_q))
		else $error("transfer address wrong");
	a_direct_source: assert property (
		state_q == S_EXEC && mode_q == M_DIRECT
		|=> !res_ea_mem && res_operand == $past(rd_a))
		else $error("direct operand wrong");
	a_lit_short: assert property (
		state_q == S_EXEC && mode_q == M_LIT5
		|=> !res_ea_mem && res_operand == {11'h000, $past(lit_q[4:0])})
		else $error("short literal wrong");
	a_indirect_plain: assert property (
		state_q == S_EXEC && mode_q == M_IND |=> res_ea == $past(rd_a))
		else $error("indirect address wrong");
	a_post_mod_ptr: assert property (
		state_q == S_EXEC && mode_q == M_POST
		|-> wr_en && wr_addr == wn_q ##1 res_ea == $past(rd_a)
		&& res_ea != $past(wr_data))
		else $error("post modify wrong");
	a_pre_mod_ptr: assert property (
		state_q == S_EXEC && mode_q == M_PRE
		|=> $past(wr_en) && res_ea == $past(wr_data))
		else $error("pre modify wrong");
	a_indexed_sum: assert property (
		state_q == S_EXEC && mode_q == M_INDEXED
		|=> res_ea == $past(rd_a) + $past(rd_b))
		else $error("indexed address wrong");
	a_table_page: assert property (
		state_q == S_EXEC && tbl_q != T_NONE && tbl_q != T_ERASE
		|=> prog_addr == {$past(pps_q), res_ea} && prog_op != T_NONE)
		else $error("table address wrong");
	a_erase_align: assert property (
		state_q == S_EXEC && tbl_q == T_ERASE
		|=> prog_addr[9:0] == 10'h000 ##1 prog_op == T_NONE)
		else $error("erase not page aligned");
	a_pair_dest: assert property (
		state_q == S_EXEC && dest_q == D_PAIR
		|=> res_dest_pair && !res_dest_mem && res_dest_reg == $past(wd_q))
		else $error("pair destination wrong");
	a_apb_answer: assert property (
		state_q == S_IDLE && apb_acc && !take_op |=> ##1 pready ##1 !pready)
		else $error("apb answer timing wrong");

	c_post_mod: cover property (state_q == S_EXEC && mode_q == M_POST);
	c_read_high: cover property (prog_op == T_RD_HIGH && prog_byte);
	c_apb_default_work_register: cover property (pready && !pslverr && apb_w[4]);
	c_pair: cover property (res_valid && res_dest_pair);

endmodule // oag_addr_gen
`default_nettype wire

// ===== oag_dec_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural decoder: issues one operand request and waits for the result
module oag_dec_model
	import oag_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Request to the generator
	output logic op_valid,
	input wire logic op_ready,
	output oag_pkg::oag_mode_t op_mode,
	output oag_pkg::oag_tbl_t op_table,
	output oag_pkg::oag_dest_t op_dest,
	output logic op_byte,
	output logic op_dec,
	output logic [3:0] op_wn,
	output logic [3:0] op_wb,
	output logic [3:0] op_wd,
	output logic [15:0] op_addr,
	output logic [9:0] op_lit,
	// Result watch
	input wire logic res_valid,
	input wire oag_pkg::oag_tbl_t prog_op,
	output oag_pkg::oag_tbl_t seen_op,
	output logic timed_out
);
	// Idle values at time zero
	initial begin
		op_valid = 1'b0;
		op_mode = M_FILE;
		op_table = T_NONE;
		op_dest = D_MEM;
		{op_byte, op_dec, op_wn, op_wb, op_wd, op_addr, op_lit} = '0;
		seen_op = T_NONE;
		timed_out = 1'b0;
	end

	// Hold the request until taken, then wait for the result pulse
	task automatic send(input oag_mode_t m, input oag_tbl_t t,
		input oag_dest_t d, input logic b, input logic dn,
		input logic [3:0] wn, input logic [3:0] wb, input logic [3:0] wd,
		input logic [15:0] a, input logic [9:0] l);
		int n;
		n = 0;
		@(posedge pclk);
		op_valid <= 1'b1;
		op_mode <= m;
		op_table <= t;
		op_dest <= d;
		op_byte <= b;
		op_dec <= dn;
		op_wn <= wn;
		op_wb <= wb;
		op_wd <= wd;
		op_addr <= a;
		op_lit <= l;
		do begin
			@(negedge pclk);
			n++;
		end while (op_ready !== 1'b1 && n < 50);
		@(posedge pclk);
		// Stale address and literal are scrambled so nothing leans on them
		op_valid <= 1'b0;
		op_addr <= ~a;
		op_lit <= ~l;
		do begin
			@(negedge pclk);
			n++;
		end while (res_valid !== 1'b1 && n < 100);
		seen_op = prog_op;
		timed_out = (n >= 100);
	endtask
endmodule // oag_dec_model
`default_nettype wire

// ===== oag_default_work_register_mem.sv
`timescale 1ns/1ps
`default_nettype none
module oag_default_work_register_mem (
	// Clock
	input wire logic clk,
	// Read port a
	input wire logic [3:0] ra_addr,
	output logic [15:0] ra_data,
	// Read port b
	input wire logic [3:0] rb_addr,
	output logic [15:0] rb_data,
	// Write port
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire logic [15:0] wr_data
);

	logic [15:0] mem [0:15];

	// Contents are undefined after reset, as for the core registers
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered reads; a same-cycle write is seen one cycle later
	always_ff @(posedge clk) begin
		ra_data <= mem[ra_addr];
		rb_data <= mem[rb_addr];
	end

endmodule // oag_default_work_register_mem
`default_nettype wire

// ===== oag_pkg.sv
`default_nettype none
package oag_pkg;

	// Operand addressing modes
	typedef enum logic [3:0] {
		M_FILE = 4'h0,
		M_FAR = 4'h1,
		M_DIRECT = 4'h2,
		M_IND = 4'h3,
		M_POST = 4'h4,
		M_PRE = 4'h5,
		M_INDEXED = 4'h6,
		M_LITOFS = 4'h7,
		M_LIT5 = 4'h8,
		M_LIT10 = 4'h9
	} oag_mode_t;

	// Program memory access kind
	typedef enum logic [2:0] {
		T_NONE = 3'h0,
		T_RD_LOW = 3'h1,
		T_WR_LOW = 3'h2,
		T_RD_HIGH = 3'h3,
		T_WR_HIGH = 3'h4,
		T_ERASE = 3'h5
	} oag_tbl_t;

	// Result destination
	typedef enum logic [1:0] {
		D_MEM = 2'h0,
		D_DEFAULT_WORK_REGISTER = 2'h1,
		D_WN = 2'h2,
		D_PAIR = 2'h3
	} oag_dest_t;

	// Sequencer states
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_EXEC = 2'h1,
		S_APB = 2'h2
	} oag_state_t;

endpackage
`default_nettype wire

// ===== oag_regs.svh
`ifndef OAG_REGS_SVH
`define OAG_REGS_SVH

// Register indices; the byte address on APB is four times the index
`define OAG_IDX_W0 16'h0000
`define OAG_IDX_W1 16'h0002
`define OAG_IDX_W2 16'h0004
`define OAG_IDX_W3 16'h0006
`define OAG_IDX_W4 16'h8000
`define OAG_IDX_W5 16'h000a
`define OAG_IDX_W6 16'h000c
`define OAG_IDX_W7 16'h000e
`define OAG_IDX_W8 16'h0010
`define OAG_IDX_W9 16'h0012
`define OAG_IDX_W10 16'h0014
`define OAG_IDX_W11 16'h0016
`define OAG_IDX_W12 16'h0018
`define OAG_IDX_W13 16'h001a
`define OAG_IDX_W14 16'h001c
`define OAG_IDX_W15 16'h001e
`define OAG_IDX_STACK_LIMIT 16'h0020
`define OAG_IDX_RDPAGE 16'h0032
`define OAG_IDX_WRPAGE 16'h0034
`define OAG_IDX_PPS 16'h0040
`define OAG_IDX_LAST_EA 16'h0042

// Reset values
`define OAG_RST_STACK_LIMIT 16'h0000
`define OAG_RST_RDPAGE 10'h001
`define OAG_RST_WRPAGE 9'h001
`define OAG_RST_PPS 8'h00

// Field sizes and constants
`define OAG_FILE_BITS 13
`define OAG_STEP_BYTE 16'h0001
`define OAG_STEP_WORD 16'h0002
// 512 instructions span 1024 program addresses
`define OAG_PAGE_MASK 24'hfffc00

`endif

// ===== operand_address_generation_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "oag_regs.svh"
module operand_address_generation_tb;
	import oag_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, op_valid, op_ready, op_byte, op_dec;
	oag_mode_t op_mode;
	oag_tbl_t op_table, prog_op, seen_op;
	oag_dest_t op_dest;
	logic [3:0] op_wn, op_wb, op_wd, res_dest_reg;
	logic [15:0] op_addr, res_ea, res_operand;
	logic [9:0] op_lit;
	logic res_valid, res_ea_mem, res_dest_pair, res_dest_mem;
	logic [23:0] prog_addr;
	logic prog_byte, prog_byte_hi, timed_out;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [31:0] q;
	logic err;

	// 50 MHz clock
	always #10 pclk = ~pclk;

	oag_addr_gen u_oag_addr_gen (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_valid(op_valid), .op_ready(op_ready),
		.op_mode(op_mode), .op_table(op_table), .op_dest(op_dest),
		.op_byte(op_byte), .op_dec(op_dec), .op_wn(op_wn), .op_wb(op_wb),
		.op_wd(op_wd), .op_addr(op_addr), .op_lit(op_lit),
		.res_valid(res_valid), .res_ea(res_ea), .res_ea_mem(res_ea_mem),
		.res_operand(res_operand), .res_dest_reg(res_dest_reg),
		.res_dest_pair(res_dest_pair), .res_dest_mem(res_dest_mem),
		.prog_addr(prog_addr), .prog_op(prog_op), .prog_byte(prog_byte),
		.prog_byte_hi(prog_byte_hi));

	oag_dec_model u_oag_dec_model (.pclk(pclk), .op_valid(op_valid),
		.op_ready(op_ready), .op_mode(op_mode), .op_table(op_table),
		.op_dest(op_dest), .op_byte(op_byte), .op_dec(op_dec),
		.op_wn(op_wn), .op_wb(op_wb), .op_wd(op_wd), .op_addr(op_addr),
		.op_lit(op_lit), .res_valid(res_valid), .prog_op(prog_op),
		.seen_op(seen_op), .timed_out(timed_out));

	// Value compare, zero-extended to 32 bits
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Program access kind compare
	task automatic chk_op(input oag_tbl_t e);
		cmp_count++;
		if (seen_op !== e || timed_out !== 1'b0) begin
			bad_count++;
			$display("[FAIL] prog_op expected %0d seen %0d", e, seen_op);
		end
	endtask

	// One APB transfer; waits for pready, only the bench timeout ends it
	task automatic apb(input logic wr, input logic [15:0] idx,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Sample at the rising edge; release only after pready is seen
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reset values, an unmapped index and W4 at its far index
	task automatic t_regs();
		apb(1'b0, `OAG_IDX_STACK_LIMIT, 32'h0);
		chk("stack_limit", 32'h0000, q);
		apb(1'b0, `OAG_IDX_RDPAGE, 32'h0);
		chk("read_page", 32'h0001, q);
		// the write page is writable from software; this step only reads its reset value
		apb(1'b0, `OAG_IDX_WRPAGE, 32'h0);
		chk("write_page", 32'h0001, q);
		apb(1'b1, 16'h3ff0, 32'h1234);
		chk("unmapped_err", 32'h1, {31'h0, err});
		apb(1'b1, `OAG_IDX_W4, 32'h0000_4444);
		apb(1'b0, `OAG_IDX_W4, 32'h0);
		chk("w4", 32'h4444, q);
		apb(1'b1, `OAG_IDX_PPS, 32'h0000_005a);
	endtask

	// Direct and indirect forms over preset working registers
	task automatic t_modes();
		apb(1'b1, `OAG_IDX_W1, 32'h1000);
		apb(1'b1, `OAG_IDX_W2, 32'h0234);
		apb(1'b1, `OAG_IDX_W3, 32'h2000);
		apb(1'b1, `OAG_IDX_W5, 32'h3000);
		u_oag_dec_model.send(M_FILE, T_NONE, D_DEFAULT_WORK_REGISTER, 0, 0, 1, 2, 7,
			16'hffff, 10'h0);
		chk("file_ea", 32'h1fff, res_ea);
		chk("file_dest", 32'h0, res_dest_reg);
		u_oag_dec_model.send(M_FAR, T_NONE, D_MEM, 0, 0, 1, 2, 7,
			16'hfffe, 10'h0);
		chk("far_ea", 32'hfffe, res_ea);
		u_oag_dec_model.send(M_IND, T_NONE, D_MEM, 0, 0, 2, 1, 7,
			16'h0, 10'h0);
		chk("ind_ea", 32'h0234, res_ea);
		u_oag_dec_model.send(M_INDEXED, T_NONE, D_MEM, 0, 0, 1, 2, 7,
			16'h0, 10'h0);
		chk("idx_ea", 32'h1234, res_ea);
		u_oag_dec_model.send(M_LITOFS, T_NONE, D_MEM, 0, 0, 1, 2, 7,
			16'h0, 10'h3f0);
		chk("litofs_ea", 32'h0ff0, res_ea);
		u_oag_dec_model.send(M_DIRECT, T_NONE, D_PAIR, 0, 0, 1, 2, 4,
			16'h0, 10'h0);
		chk("pair", 32'h1, {31'h0, res_dest_pair});
		chk("pair_mem", 32'h0, {31'h0, res_dest_mem});
		chk("direct_val", 32'h1000, res_operand);
	endtask

	// Modify forms, back to back, then the written-back registers
	task automatic t_modify();
		u_oag_dec_model.send(M_POST, T_NONE, D_MEM, 0, 0, 3, 0, 7,
			16'h0, 10'h0);
		chk("post_ea", 32'h2000, res_ea);
		u_oag_dec_model.send(M_PRE, T_NONE, D_MEM, 1, 1, 5, 0, 7,
			16'h0, 10'h0);
		chk("pre_ea", 32'h2fff, res_ea);
		apb(1'b0, `OAG_IDX_W3, 32'h0);
		chk("w3_after", 32'h2002, q);
		apb(1'b0, `OAG_IDX_W5, 32'h0);
		chk("w5_after", 32'h2fff, q);
	endtask

	// Literal sources, destination kinds and the T_WR_LOW and T_RD_HIGH table kinds
	task automatic t_lits();
		u_oag_dec_model.send(M_LIT5, T_NONE, D_WN, 0, 0, 1, 2, 9,
			16'h0, 10'h3f5);
		chk("lit5_val", 32'h0015, res_operand);
		chk("lit5_mem", 32'h0, {31'h0, res_ea_mem});
		chk("wn_dest", 32'h9, res_dest_reg);
		chk("wn_mem", 32'h0, {31'h0, res_dest_mem});
		u_oag_dec_model.send(M_LIT10, T_WR_LOW, D_MEM, 0, 0, 1, 2, 9,
			16'h0, 10'h3f5);
		chk("lit10_val", 32'h03f5, res_operand);
		chk("mem_dest", 32'h1, {31'h0, res_dest_mem});
		chk("wrl_word", 32'h0, {31'h0, prog_byte});
		chk_op(T_WR_LOW);
		u_oag_dec_model.send(M_IND, T_RD_HIGH, D_WN, 1, 0, 2, 0, 9,
			16'h0, 10'h0);
		chk("ind_mem", 32'h1, {31'h0, res_ea_mem});
		chk("rdh_addr", 32'h5a0234, prog_addr);
		chk("rdh_byte", 32'h1, {31'h0, prog_byte});
		chk("rdh_byte_hi", 32'h0, {31'h0, prog_byte_hi});
		chk_op(T_RD_HIGH);
		apb(1'b0, `OAG_IDX_LAST_EA, 32'h0);
		chk("last_ea", 32'h0234, q);
		chk("good_err", 32'h0, {31'h0, err});
	endtask

	// Table access forms program addresses under the page select
	task automatic t_table();
		u_oag_dec_model.send(M_IND, T_RD_LOW, D_WN, 0, 0, 1, 0, 7,
			16'h0, 10'h0);
		chk("tbl_lo_addr", 32'h5a1000, prog_addr);
		chk_op(T_RD_LOW);
		u_oag_dec_model.send(M_IND, T_WR_HIGH, D_MEM, 1, 0, 5, 0, 7,
			16'h0, 10'h0);
		chk("tbl_hi_addr", 32'h5a2fff, prog_addr);
		chk_op(T_WR_HIGH);
		chk("tbl_byte_hi", 32'h1, {31'h0, prog_byte_hi});
		u_oag_dec_model.send(M_IND, T_ERASE, D_MEM, 0, 0, 3, 0, 7,
			16'h0, 10'h0);
		chk("erase_addr", 32'h5a2000 & `OAG_PAGE_MASK, prog_addr);
		chk_op(T_ERASE);
	endtask

	// Verdict and end of run
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Cycle ceiling well above the hundred-odd cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			results();
		end
	end

	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_regs();
		t_modes();
		t_modify();
		t_lits();
		t_table();
		results();
	end
endmodule // operand_address_generation_tb
`default_nettype wire
